// >>> sase_pkg.sv
// Package for the skip / subtract / swap execution slice of the core.
// Assumes a single core clock; memory lives outside this block, flags are held in sase_exec.
package sase_pkg;
  localparam int DATA_W = 8;

  // Operation codes presented by instruction decode
  typedef enum logic [2:0]
  {
    OP_NONE                 = 3'h0,
    OP_DEC_SKIP_ZERO        = 3'h1,
    OP_DEC_TO_ACC_SKIP_ZERO = 3'h2,
    OP_INC_SKIP_ZERO        = 3'h3,
    OP_INC_TO_ACC_SKIP_ZERO = 3'h4,
    OP_SKIP_BIT_NONZERO     = 3'h5,
    OP_SUB_IMM              = 3'h6,
    OP_SWAP                 = 3'h7
  } sase_op_t;

  localparam logic [7:0] ACC_RESET   = 8'h00;
  localparam logic [7:0] ONE_BYTE    = 8'h01;
  localparam int         NIB_LO_MSB  = 3;
  localparam int         NIB_HI_LSB  = 4;
  localparam int         SKIP_CYCLES = 1;

  // Request from decode
  typedef struct packed
  {
    logic       valid;
    sase_op_t   op;
    logic [7:0] mem;
    logic [7:0] imm;
    logic [2:0] bit_sel;
  } sase_req_t;

  // Status flags
  typedef struct packed
  {
    logic signed_wrap_flag;
    logic zero;
    logic nibble_carry_flag;
    logic carry;
  } sase_flags_t;

  // Adder result
  typedef struct packed
  {
    logic [7:0]  sum;
    sase_flags_t flags;
  } sase_sum_t;
endpackage : sase_pkg

// >>> sase_sub_adder.sv
// Subtract adder: a + ~b + 1 with flag outputs.
// Assumes purely combinational use by the execution top.
`timescale 1ns/1ps
module sase_sub_adder
  import sase_pkg::*;
(
  // Operands
  input  wire logic [7:0] i_a,
  input  wire logic [7:0] i_b,
  // Result
  output sase_sum_t       o_res
);
  logic [8:0] full;
  logic [4:0] low;
  logic [7:0] nb;

  assign nb   = ~i_b;
  assign full = {1'b0, i_a} + {1'b0, nb} + 9'h001;
  assign low  = {1'b0, i_a[3:0]} + {1'b0, nb[3:0]} + 5'h01;
  assign o_res.sum                     = full[7:0];
  assign o_res.flags.carry             = full[8];
  assign o_res.flags.nibble_carry_flag = low[4];
  assign o_res.flags.zero              = (full[7:0] == 8'h00);
  // Signed wrap: a and b of opposite sign give a result of other sign than a
  assign o_res.flags.signed_wrap_flag  =
    (i_a[7] == nb[7]) && (full[7] != i_a[7]);
endmodule : sase_sub_adder

// >>> sase_exec.sv
// Execution unit for skip-on-result, subtract-immediate and nibble swap.
// Assumes decode presents one request per cycle and the fetch unit honours
// o_skip by turning the prefetched instruction into a dummy cycle.
//
// How it works
// - Decrement memory byte and write back; skip next on zero.
// - Increment memory byte and write back; test the same sum for zero in that cycle.
// - Zero increment result discards prefetched instruction; two cycles.
// - Inc-to-accumulator form loads byte plus one; skip next on zero.
// - Increment-to-accumulator leaves the memory byte untouched.
// - Zero inc-to-accumulator result turns fetched word into dummy.
// - Selected bit one skips next instruction; bit zero runs one cycle.
// - Subtract immediate: acc + ~imm + 1 into acc; update four flags.
// - Swap exchanges memory nibbles in place, flags unchanged.
`timescale 1ns/1ps
module sase_exec
  import sase_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  // Decode request
  input  sase_req_t        i_req,
  // Memory write-back
  output logic             o_mem_we,
  output logic [7:0]       o_mem_wdata,
  // Accumulator and flags
  output logic [7:0]       o_acc,
  output sase_flags_t      o_flags,
  // Fetch control: discard prefetched instruction
  output logic             o_skip
);
  sase_sum_t  sub_res;
  logic [7:0] dec_val;
  logic [7:0] inc_val;
  logic [7:0] swp_val;
  logic       bit_set;
  logic       go;
  logic       dummy;

  // Zero test shared by every skip-on-result form
  function automatic logic is_zero(input logic [7:0] v);
    is_zero = (v == 8'h00);
  endfunction : is_zero

  sase_sub_adder u_sub
  (
    .i_a   (o_acc),
    .i_b   (i_req.imm),
    .o_res (sub_res)
  );

  assign dec_val = i_req.mem - ONE_BYTE;
  assign inc_val = i_req.mem + ONE_BYTE;
  assign swp_val = {i_req.mem[NIB_LO_MSB:0], i_req.mem[7:NIB_HI_LSB]};
  assign bit_set = i_req.mem[i_req.bit_sel];
  // A request landing in the dummy slot belongs to the discarded word
  assign go      = i_req.valid && !dummy;

  // Memory write-back
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_mem_we    <= 1'b0;
      o_mem_wdata <= 8'h00;
    end
    else
    begin
      o_mem_we    <= 1'b0;
      o_mem_wdata <= o_mem_wdata;
      if (go)
      begin
        case (i_req.op)
          OP_DEC_SKIP_ZERO:
          begin
            o_mem_we    <= 1'b1;
            o_mem_wdata <= dec_val;
          end
          OP_INC_SKIP_ZERO:
          begin
            o_mem_we    <= 1'b1;
            o_mem_wdata <= inc_val;
          end
          OP_SWAP:
          begin
            o_mem_we    <= 1'b1;
            o_mem_wdata <= swp_val;
          end
          // Accumulator forms never write memory
          default: o_mem_we <= 1'b0;
        endcase
      end
    end
  end

  // Accumulator
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_acc <= ACC_RESET;
    else if (go)
    begin
      case (i_req.op)
        OP_INC_TO_ACC_SKIP_ZERO: o_acc <= inc_val;
        OP_DEC_TO_ACC_SKIP_ZERO: o_acc <= dec_val;
        OP_SUB_IMM:              o_acc <= sub_res.sum;
        default:                 o_acc <= o_acc;
      endcase
    end
  end

  // Flags: only subtract touches them
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_flags <= '0;
    else if (go && i_req.op == OP_SUB_IMM)
      o_flags <= sub_res.flags;
  end

  // Skip decision, registered so fetch sees it in the following cycle
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_skip <= 1'b0;
    else if (go)
    begin
      case (i_req.op)
        OP_DEC_SKIP_ZERO:        o_skip <= is_zero(dec_val);
        OP_INC_SKIP_ZERO:        o_skip <= is_zero(inc_val);
        OP_INC_TO_ACC_SKIP_ZERO: o_skip <= is_zero(inc_val);
        OP_DEC_TO_ACC_SKIP_ZERO: o_skip <= is_zero(dec_val);
        OP_SKIP_BIT_NONZERO:     o_skip <= bit_set;
        default:                 o_skip <= 1'b0;
      endcase
    end
    else
      o_skip <= 1'b0;
  end

  // Dummy cycle marker, one cycle after a skip
  assign dummy = o_skip;

  dec_write_a : assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (go && i_req.op == OP_DEC_SKIP_ZERO) |=>
      o_mem_we && o_mem_wdata == $past(i_req.mem) - 8'h01)
    else $error("decrement write-back wrong");

  dec_skip_a : assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (go && i_req.op == OP_DEC_SKIP_ZERO) |=>
      o_skip == ($past(i_req.mem) == 8'h01))
    else $error("decrement skip wrong");

  inc_write_a : assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (go && i_req.op == OP_INC_SKIP_ZERO) |=>
      o_mem_we && o_mem_wdata == $past(i_req.mem) + 8'h01)
    else $error("increment write-back wrong");

  inc_skip_a : assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (go && i_req.op == OP_INC_SKIP_ZERO && i_req.mem == 8'hFF) |=>
      o_skip ##1 !o_skip)
    else $error("increment skip not one dummy cycle");

  inc_acc_a : assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (go && i_req.op == OP_INC_TO_ACC_SKIP_ZERO) |=>
      o_acc == $past(i_req.mem) + 8'h01 && o_skip == (o_acc == 8'h00))
    else $error("increment to accumulator wrong");

  acc_nowrite_a : assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (go && (i_req.op == OP_INC_TO_ACC_SKIP_ZERO ||
            i_req.op == OP_DEC_TO_ACC_SKIP_ZERO)) |=> !o_mem_we)
    else $error("accumulator form wrote memory");

  acc_dummy_a : assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    o_skip |=> !o_mem_we && $stable(o_acc) && $stable(o_flags))
    else $error("dummy cycle had side effects");

  // A skip longer than one cycle would swallow a real instruction
  skip_pulse_a : assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    o_skip |=> !o_skip)
    else $error("skip held past the dummy cycle");

  bit_skip_a : assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (go && i_req.op == OP_SKIP_BIT_NONZERO) |=>
      o_skip == $past(i_req.mem[i_req.bit_sel]) && !o_mem_we)
    else $error("bit skip wrong");

  sub_imm_a : assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (go && i_req.op == OP_SUB_IMM) |=>
      o_acc == $past(o_acc) - $past(i_req.imm) &&
      o_flags.zero == (o_acc == 8'h00))
    else $error("subtract immediate wrong");

  // Carry outs read as no-borrow, checked against plain magnitudes
  sub_carry_a : assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (go && i_req.op == OP_SUB_IMM) |=>
      o_flags.carry == ($past(o_acc) >= $past(i_req.imm)) &&
      o_flags.nibble_carry_flag ==
        ($past(o_acc[3:0]) >= $past(i_req.imm[3:0])))
    else $error("subtract carry flags wrong");

  swap_keep_a : assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (go && i_req.op == OP_SWAP) |=>
      o_mem_we &&
      o_mem_wdata == {$past(i_req.mem[3:0]), $past(i_req.mem[7:4])} &&
      $stable(o_flags))
    else $error("swap wrong");

  dec_acc_a : assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (go && i_req.op == OP_DEC_TO_ACC_SKIP_ZERO) |=>
      o_acc == $past(i_req.mem) - 8'h01 && o_skip == (o_acc == 8'h00))
    else $error("decrement to accumulator wrong");
endmodule : sase_exec

// >>> tb_top.sv
// Self-checking bench for the skip / subtract / swap execution unit.
// Assumes sase_pkg is compiled first; the bench plays decode and fetch.
`timescale 1ns/1ps
module tb_top;
  import sase_pkg::*;

  typedef struct packed
  {
    int          cyc;
    logic        we;
    logic [7:0]  wd;
    logic [7:0]  acc;
    sase_flags_t fl;
    logic        skip;
  } sase_note_t;

  logic        i_clk     = 1'b0;
  logic        i_rst_b   = 1'b0;
  sase_req_t   i_req     = '0;
  logic        o_mem_we;
  logic [7:0]  o_mem_wdata;
  logic [7:0]  o_acc;
  sase_flags_t o_flags;
  logic        o_skip;
  sase_note_t  q[$];
  sase_note_t  m         = '0;
  sase_note_t  n;
  int          bad_count = 0;
  int          checks    = 0;
  int          cyc       = 0;
  int          seed      = 32'hCF64D584;

  always #50 i_clk = ~i_clk;

  sase_exec sase_exec_inst
  (
    .i_clk       (i_clk),
    .i_rst_b     (i_rst_b),
    .i_req       (i_req),
    .o_mem_we    (o_mem_we),
    .o_mem_wdata (o_mem_wdata),
    .o_acc       (o_acc),
    .o_flags     (o_flags),
    .o_skip      (o_skip)
  );

  task conclude;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude

  task chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    checks++;
    if (s !== e)
    begin
      $display("[ERR] %s expected %h seen %h", nm, e, s);
      bad_count++;
    end
  endtask : chk

  // Hang guard: the whole run needs well under this many cycles
  always @(posedge i_clk)
  begin
    cyc = cyc + 1;
    if (cyc == 4000)
    begin
      bad_count++;
      conclude();
    end
  end

  // Every driven cycle leaves one note, so idle outputs are checked too
  always @(negedge i_clk)
    if (q.size() > 0 && q[0].cyc == cyc)
    begin
      n = q.pop_front();
      chk("mem_we", {7'h00, n.we}, {7'h00, o_mem_we});
      chk("mem_wdata", n.wd, o_mem_wdata);
      chk("acc", n.acc, o_acc);
      chk("flags", {4'h0, n.fl}, {4'h0, o_flags});
      chk("skip", {7'h00, n.skip}, {7'h00, o_skip});
    end

  task drive(input sase_op_t op, input logic [7:0] mem,
             input logic [7:0] imm = 8'h00, input logic [2:0] bs = 3'h0,
             input logic v = 1'b1);
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] r;
    logic       skp;
    i_req <= '{v, op, mem, imm, bs};
    skp = 1'b0;
    m.we = 1'b0;
    r = (op == OP_DEC_SKIP_ZERO || op == OP_DEC_TO_ACC_SKIP_ZERO) ?
        mem - 8'h01 : mem + 8'h01;
    // A word offered during the dummy cycle is dropped
    if (!m.skip && v)
      case (op)
        OP_DEC_SKIP_ZERO, OP_INC_SKIP_ZERO:
          {m.we, m.wd, skp} = {1'b1, r, r == 8'h00};
        OP_DEC_TO_ACC_SKIP_ZERO, OP_INC_TO_ACC_SKIP_ZERO:
          {m.acc, skp} = {r, r == 8'h00};
        OP_SKIP_BIT_NONZERO:
          skp = mem[bs];
        OP_SUB_IMM:
        begin
          s = {1'b0, m.acc} + {1'b0, ~imm} + 9'h001;
          h = {1'b0, m.acc[3:0]} + {1'b0, ~imm[3:0]} + 5'h01;
          m.fl = '{(m.acc[7] != imm[7]) && (s[7] != m.acc[7]),
                   s[7:0] == 8'h00, h[4], s[8]};
          m.acc = s[7:0];
        end
        OP_SWAP:
          {m.we, m.wd} = {1'b1, mem[3:0], mem[7:4]};
        default: ;
      endcase
    m.skip = skp;
    m.cyc = cyc + 1;
    q.push_back(m);
    @(posedge i_clk);
    #1;
  endtask : drive

  initial
  begin
    repeat (2) @(posedge i_clk);
    #1 i_rst_b = 1'b1;
    drive(OP_NONE, 8'h00, 8'h00, 3'h0, 1'b0);
    drive(OP_DEC_SKIP_ZERO, 8'h00);
    drive(OP_DEC_SKIP_ZERO, 8'h01);
    drive(OP_SWAP, 8'h3C);
    drive(OP_INC_SKIP_ZERO, 8'hFF);
    drive(OP_INC_SKIP_ZERO, 8'h7F);
    drive(OP_INC_SKIP_ZERO, 8'h7F);
    drive(OP_INC_TO_ACC_SKIP_ZERO, 8'hFF);
    drive(OP_NONE, 8'h00);
    drive(OP_INC_TO_ACC_SKIP_ZERO, 8'h7F);
    drive(OP_SUB_IMM, 8'h00, 8'h01);
    drive(OP_SUB_IMM, 8'h00, 8'h80);
    drive(OP_SUB_IMM, 8'h00, 8'hFF);
    drive(OP_DEC_TO_ACC_SKIP_ZERO, 8'h01);
    drive(OP_NONE, 8'h00);
    drive(OP_SWAP, 8'h3C);
    for (int i = 0; i < 8; i++)
    begin
      drive(OP_SKIP_BIT_NONZERO, 8'hA5, 8'h00, 3'(i));
      drive(OP_NONE, 8'h00);
    end
    repeat (400)
      drive(sase_op_t'(3'($random(seed))), 8'($random(seed)),
            8'($random(seed)), 3'($random(seed)), 1'($random(seed)));
    drive(OP_NONE, 8'h00);
    drive(OP_NONE, 8'h00);
    // Let the last note be compared before the verdict
    @(negedge i_clk);
    #1;
    conclude();
  end
endmodule : tb_top
